// File: dv/serial_port_spi_mode_chk.sv
// Port assertions for the SPI-mode serial engine.
// Assumes one clock domain and zero-wait APB access.
`timescale 1ns/100ps
module serial_port_spi_mode_chk
	import serial_port_spi_mode_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txd_oe,
	input wire logic        rxd_claim,
	input wire logic        bit_rate_tick,
	input wire logic        irq_tx_complete,
	input wire logic        irq_tx_empty,
	input wire logic        irq_tx_complete_ack
);
	wire [7:0] ix  = paddr[9:2];
	wire       hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && ix inside {SERIAL_PORT_SPI_MODE_IDX_STATUS,
		SERIAL_PORT_SPI_MODE_IDX_CTRL, SERIAL_PORT_SPI_MODE_IDX_FMT, SERIAL_PORT_SPI_MODE_IDX_BAUDL, SERIAL_PORT_SPI_MODE_IDX_BAUDH, SERIAL_PORT_SPI_MODE_IDX_DATA};
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence acc_s;
		psel && penable;
	endsequence
	sequence dwr_s;
		acc_s ##0 (pwrite && hit && ix == SERIAL_PORT_SPI_MODE_IDX_DATA);
	endsequence
	ready_now_a: assert property (acc_s |-> pready)
		else $error("access without ready");
	unmapped_err_a: assert property (acc_s ##0 (!hit && !pwrite) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc_s ##0 hit |-> !pslverr)
		else $error("mapped access refused");
	upper_zero_a: assert property (acc_s |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	empty_clear_a: assert property (dwr_s |=> !irq_tx_empty)
		else $error("empty request after data write");
	ack_clears_a: assert property (irq_tx_complete_ack |=> !irq_tx_complete)
		else $error("complete request after ack");
	tick_spacing_a: assert property (bit_rate_tick |=> !bit_rate_tick)
		else $error("bit ticks too close");
	claim_needs_tx_a: assert property (rxd_claim |-> txd_oe)
		else $error("receive pin claimed without transmitter");
endmodule
bind serial_port_spi_mode_engine serial_port_spi_mode_chk chk_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .txd_oe(txd_oe), .rxd_claim(rxd_claim), .bit_rate_tick(bit_rate_tick),
	.irq_tx_complete(irq_tx_complete), .irq_tx_empty(irq_tx_empty),
	.irq_tx_complete_ack(irq_tx_complete_ack));

// File: dv/serial_port_spi_mode_peer.sv
// SPI slave model facing the engine when it runs as master.
// Assumes the bench holds sync high while it changes the format.
`timescale 1ns/100ps
module serial_port_spi_mode_peer
(
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sync,
	input  wire logic       pol,
	input  wire logic       pha,
	input  wire logic       lsb,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      got,
	output int              frames
);
	logic [7:0] sh;
	int         n;
	wire        lead = sck ^ pol;
	initial
	begin
		frames = 0;
		n = 0;
		miso = 1'b1;
	end
	// Each frame sends the base byte plus the frame count.
	function automatic logic pick(input int i);
		logic [7:0] v;
		v = tx + frames[7:0];
		return lsb ? v[i] : v[7 - i];
	endfunction
	task automatic take();
		sh[lsb ? n : 7 - n] = mosi;
		n++;
		if (n == 8)
		begin
			got = sh;
			frames++;
			n = 0;
		end
	endtask
	always @(sync or tx or lsb)
		if (sync)
		begin
			n = 0;
			miso = pick(0);
		end
	always @(posedge lead)
		if (!sync)
		begin
			if (pha)
				miso = pick(n);
			else
				take();
		end
	always @(negedge lead)
		if (!sync)
		begin
			if (pha)
				take();
			else
				miso = pick(n);
		end
endmodule

// File: dv/usart_spi_mode_engine_bench.sv
// Register-level bench for the SPI-mode serial engine with a slave peer.
// Assumes zero-wait APB and the engine as SPI master.
`timescale 1ns/100ps
module usart_spi_mode_engine_bench;
	import serial_port_spi_mode_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic        ack     = 1'b0;
	logic        sync    = 1'b1;
	logic        pol     = 1'b0;
	logic        pha     = 1'b0;
	logic        lsb     = 1'b0;
	logic [7:0]  ptx     = 8'h00;
	logic [31:0] prdata, rdv;
	logic        pready, pslverr, xck_o, xck_oe, txd_o, txd_oe, miso, claim, tick, errv;
	logic        irq_rx, irq_tc, irq_te;
	logic [7:0]  got;
	int          frames, f0;
	int          bad_count = 0;
	int          n_tests   = 0;
	logic [7:0]  ixs [6] = '{SERIAL_PORT_SPI_MODE_IDX_STATUS, SERIAL_PORT_SPI_MODE_IDX_CTRL, SERIAL_PORT_SPI_MODE_IDX_FMT, SERIAL_PORT_SPI_MODE_IDX_BAUDL,
		SERIAL_PORT_SPI_MODE_IDX_BAUDH, SERIAL_PORT_SPI_MODE_IDX_DATA};
	logic [7:0]  rsv [6] = '{SERIAL_PORT_SPI_MODE_RST_STATUS, SERIAL_PORT_SPI_MODE_RST_CTRL, SERIAL_PORT_SPI_MODE_RST_FMT, SERIAL_PORT_SPI_MODE_RST_BAUDL,
		{4'h0, SERIAL_PORT_SPI_MODE_RST_BAUDH}, SERIAL_PORT_SPI_MODE_RST_DATA};
	always #50 sys_clk = ~sys_clk;
	serial_port_spi_mode_engine dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xck_i(1'b0), .xck_o(xck_o), .xck_oe(xck_oe), .txd_o(txd_o),
		.txd_oe(txd_oe), .rxd_i(miso), .rxd_claim(claim), .bit_rate_tick(tick),
		.irq_rx_complete(irq_rx), .irq_tx_complete(irq_tc), .irq_tx_empty(irq_te),
		.irq_tx_complete_ack(ack));
	serial_port_spi_mode_peer peer_u (.sck(xck_o), .mosi(txd_o), .sync(sync), .pol(pol), .pha(pha),
		.lsb(lsb), .tx(ptx), .miso(miso), .got(got), .frames(frames));
	task stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] exp, input logic [31:0] act);
		n_tests++;
		if (act !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, act);
		end
	endtask
	task apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, ix, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] ix, input logic [7:0] exp);
		apb(1'b0, ix, 8'h00);
		chk({24'h0, exp}, rdv);
	endtask
	task wr(input logic [7:0] ix, input logic [7:0] wd);
		apb(1'b1, ix, wd);
	endtask
	task wait_st(input int b);
		for (int i = 0; i < 200; i++)
		begin
			apb(1'b0, SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h00);
			if (rdv[b] === 1'b1)
				break;
		end
		chk(32'h1, {31'h0, rdv[b]});
	endtask
	task gap(input int exp);
		int c;
		c = 0;
		@(negedge sys_clk iff tick === 1'b1);
		do
		begin
			@(negedge sys_clk);
			c++;
		end
		while (tick !== 1'b1 && c < 1000);
		chk(exp, c);
	endtask
	task cfg(input logic [2:0] k);
		sync <= 1'b1;
		wr(SERIAL_PORT_SPI_MODE_IDX_FMT, {5'b11000, k});
		pol <= k[0];
		pha <= k[1];
		lsb <= k[2];
		ptx <= 8'h3a + k;
		repeat (2) @(posedge sys_clk);
		sync <= 1'b0;
		@(posedge sys_clk);
		f0 = frames;
	endtask
	initial
	begin
		#(30000 * 100);
		bad_count++;
		stop_test();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(ixs[i], rsv[i]);
		apb(1'b0, 8'hc3, 8'h00);
		chk(32'h1, {31'h0, errv});
		chk(32'h0, rdv);
		$display("test reset done");
		wr(SERIAL_PORT_SPI_MODE_IDX_BAUDL, 8'h02);
		wr(SERIAL_PORT_SPI_MODE_IDX_BAUDH, 8'hf0);
		rd(SERIAL_PORT_SPI_MODE_IDX_BAUDH, 8'h00);
		rd(SERIAL_PORT_SPI_MODE_IDX_BAUDL, 8'h02);
		gap(48);
		wr(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h02);
		gap(24);
		wr(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			wr(SERIAL_PORT_SPI_MODE_IDX_FMT, {m[1:0], 6'h00});
			@(negedge sys_clk);
			chk({31'h0, m[0]}, {31'h0, xck_oe});
		end
		gap(6);
		$display("test baud done");
		wr(SERIAL_PORT_SPI_MODE_IDX_CTRL, 8'h18);
		for (int k = 0; k < 8; k++)
		begin
			cfg(k[2:0]);
			wr(SERIAL_PORT_SPI_MODE_IDX_DATA, 8'hc5 ^ k[7:0]);
			wait_st(SERIAL_PORT_SPI_MODE_ST_TXC);
			chk({24'h0, 8'hc5 ^ k[7:0]}, {24'h0, got});
			rd(SERIAL_PORT_SPI_MODE_IDX_DATA, ptx + f0[7:0]);
			wr(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h40);
			rd(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h20);
		end
		$display("test modes done");
		cfg(3'b000);
		for (int i = 0; i < 3; i++)
		begin
			wait_st(SERIAL_PORT_SPI_MODE_ST_TX_BUFFER_EMPTY_FLAG);
			wr(SERIAL_PORT_SPI_MODE_IDX_DATA, 8'h90 + i[7:0]);
		end
		wait_st(SERIAL_PORT_SPI_MODE_ST_TXC);
		chk(f0 + 3, frames);
		rd(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'he0);
		rd(SERIAL_PORT_SPI_MODE_IDX_DATA, ptx + f0[7:0]);
		rd(SERIAL_PORT_SPI_MODE_IDX_DATA, ptx + f0[7:0] + 8'h01);
		rd(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h60);
		wr(SERIAL_PORT_SPI_MODE_IDX_CTRL, 8'h78);
		repeat (2) @(negedge sys_clk);
		chk(32'h1, {31'h0, irq_te});
		chk(32'h1, {31'h0, irq_tc});
		@(posedge sys_clk);
		ack <= 1'b1;
		@(posedge sys_clk);
		ack <= 1'b0;
		@(negedge sys_clk);
		chk(32'h0, {31'h0, irq_tc});
		$display("test fifo done");
		wr(SERIAL_PORT_SPI_MODE_IDX_DATA, 8'h5a);
		wr(SERIAL_PORT_SPI_MODE_IDX_CTRL, 8'h00);
		@(negedge sys_clk);
		chk(32'h1, {31'h0, txd_oe});
		chk(32'h0, {31'h0, claim});
		wait_st(SERIAL_PORT_SPI_MODE_ST_TXC);
		repeat (2) @(negedge sys_clk);
		chk(32'h0, {31'h0, txd_oe});
		rd(SERIAL_PORT_SPI_MODE_IDX_STATUS, 8'h60);
		$display("test disable done");
		stop_test();
	end
endmodule

// File: src/serial_port_spi_mode_engine.sv
// Serial port engine in SPI mode: APB register file, baud generator,
// transmit buffer, two-entry receive FIFO and the shifter.
// Assumes pins come from another domain and software sets the pin directions.
//
// Local design decision: the APB slave port.

`timescale 1ns/100ps

module serial_port_spi_mode_engine
	import serial_port_spi_mode_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xck_i,
	output logic             xck_o,
	output logic             xck_oe,
	output logic             txd_o,
	output logic             txd_oe,
	input  wire logic        rxd_i,
	output logic             rxd_claim,
	output logic             bit_rate_tick,
	output logic             irq_rx_complete,
	output logic             irq_tx_complete,
	output logic             irq_tx_empty,
	input  wire logic        irq_tx_complete_ack
);

	function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
		out_bit = lsb_first ? sh[0] : sh[7];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic lsb_first,
		input logic b);
		shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction

	logic [7:0]  ctrl_q;
	logic [7:0]  fmt_q;
	logic [7:0]  baudl_q;
	logic [3:0]  baudh_q;
	logic        u2x_q;
	logic        txc_q;
	logic [7:0]  txbuf_q;
	logic        txfull_q;
	logic        tx_active_q;
	logic [7:0]  tx_sh_q;
	logic [7:0]  rx_sh_q;
	logic        txd_q;
	logic [2:0]  bcnt_q;
	logic [3:0]  ecnt_q;
	logic        clk_q;
	serial_port_spi_mode_state_t state_q;
	logic [7:0]  rx_mem [2];
	logic        rx_wp_q;
	logic        rx_rp_q;
	logic [1:0]  rx_cnt_q;
	logic [11:0] div_cnt_q;
	logic [3:0]  pre_cnt_q;
	logic [31:0] prdata_q;
	logic        xck_s1_q;
	logic        xck_s2_q;
	logic        xck_s3_q;
	logic        rxd_s1_q;
	logic        rxd_s2_q;

	// APB decode; the word index sits in paddr[9:2].
	wire         addr_ok   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	wire  [7:0]  idx       = paddr[9:2];
	wire         hit_st    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_STATUS);
	wire         hit_ct    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_CTRL);
	wire         hit_fm    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_FMT);
	wire         hit_bl    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_BAUDL);
	wire         hit_bh    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_BAUDH);
	wire         hit_dr    = addr_ok && (idx == SERIAL_PORT_SPI_MODE_IDX_DATA);
	wire         mapped    = hit_st | hit_ct | hit_fm | hit_bl | hit_bh | hit_dr;
	wire         acc       = psel && penable;
	wire         wr        = acc && pwrite && mapped;
	wire  [7:0]  wd        = pwdata[7:0];
	wire         wr_data   = wr && hit_dr;
	wire         rd_pop    = acc && !pwrite && hit_dr && (rx_cnt_q != 2'd0);

	// Effective mode and format fields.
	// mode field decode
	wire  [1:0]  mode      = fmt_q[SERIAL_PORT_SPI_MODE_FM_MODE_HI:SERIAL_PORT_SPI_MODE_FM_MODE_LO];
	wire         is_master = (mode == SERIAL_PORT_SPI_MODE_MODE_MASTER) || (mode == SERIAL_PORT_SPI_MODE_MODE_SYNC);
	wire         is_slave  = (mode == SERIAL_PORT_SPI_MODE_MODE_SLAVE);
	wire         cpol      = fmt_q[SERIAL_PORT_SPI_MODE_FM_POL];
	wire         cpha      = (mode == SERIAL_PORT_SPI_MODE_MODE_SYNC) ? 1'b1 : fmt_q[SERIAL_PORT_SPI_MODE_FM_PHASE];
	wire         lsb_first = (mode == SERIAL_PORT_SPI_MODE_MODE_SYNC) ? 1'b0 : fmt_q[SERIAL_PORT_SPI_MODE_FM_ORDER];
	wire         transmitter_enable      = ctrl_q[SERIAL_PORT_SPI_MODE_CT_TRANSMITTER_ENABLE];
	wire         rx_on     = ctrl_q[SERIAL_PORT_SPI_MODE_CT_RECEIVER_ENABLE] && tx_active_q;
	wire         busy      = (state_q == SERIAL_PORT_SPI_MODE_ST_SHIFT);

	wire  [11:0] divisor   = {baudh_q, baudl_q};
	wire         pre_tick  = (div_cnt_q == divisor);
	wire  [3:0]  fac_last  = (mode != SERIAL_PORT_SPI_MODE_MODE_ASYNC) ? SERIAL_PORT_SPI_MODE_FAC_SYNC :
		(u2x_q ? SERIAL_PORT_SPI_MODE_FAC_DOUBLE : SERIAL_PORT_SPI_MODE_FAC_ASYNC);

	// Edge events on the transfer clock, from either source.
	// master edge from baud
	wire         mst_edge  = busy && is_master && pre_tick;
	wire         slv_edge  = busy && is_slave && (xck_s2_q != xck_s3_q);
	wire         lead_edge = (mst_edge && (clk_q == cpol)) || (slv_edge && (xck_s2_q != cpol));
	wire         trail_edge = (mst_edge && (clk_q != cpol)) || (slv_edge && (xck_s2_q == cpol));
	wire         sample    = cpha ? trail_edge : lead_edge;
	wire         setup     = cpha ? lead_edge : trail_edge;
	wire         last_samp = sample && (bcnt_q == SERIAL_PORT_SPI_MODE_LAST_BIT);
	wire         frame_end = is_master ? (mst_edge && (ecnt_q == SERIAL_PORT_SPI_MODE_LAST_EDGE)) : last_samp;
	wire         load      = !busy && txfull_q && tx_active_q && (mode != SERIAL_PORT_SPI_MODE_MODE_ASYNC);
	wire         rx_push   = last_samp && rx_on && (rx_cnt_q != 2'd2);
	wire         rx_flush  = !ctrl_q[SERIAL_PORT_SPI_MODE_CT_RECEIVER_ENABLE];

	// Read mux; unmapped reads return zero.
	wire  [7:0]  st_rd     = {rx_cnt_q != 2'd0, txc_q, !txfull_q, 3'b000, u2x_q, 1'b0};
	wire  [7:0]  rd_byte   = hit_st ? st_rd :
		hit_ct ? {ctrl_q[7:3], 3'b000} :
		hit_fm ? fmt_q :
		hit_bl ? baudl_q :
		hit_bh ? {4'h0, baudh_q} :
		(hit_dr && (rx_cnt_q != 2'd0)) ? rx_mem[rx_rp_q] : 8'h00;

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata  = prdata_q;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_q <= {24'h00_0000, rd_byte};
	end

	// Pin synchronisers.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			xck_s1_q <= 1'b0;
			xck_s2_q <= 1'b0;
			xck_s3_q <= 1'b0;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end
		else
		begin
			xck_s1_q <= xck_i;
			xck_s2_q <= xck_s1_q;
			xck_s3_q <= xck_s2_q;
			rxd_s1_q <= rxd_i;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Configuration registers.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q  <= SERIAL_PORT_SPI_MODE_RST_CTRL;
			fmt_q   <= SERIAL_PORT_SPI_MODE_RST_FMT;
			baudl_q <= SERIAL_PORT_SPI_MODE_RST_BAUDL;
			baudh_q <= SERIAL_PORT_SPI_MODE_RST_BAUDH;
			u2x_q   <= SERIAL_PORT_SPI_MODE_RST_STATUS[SERIAL_PORT_SPI_MODE_ST_U2X];
		end
		else if (wr)
		begin
			if (hit_ct)
				ctrl_q <= {wd[7:3], 3'b000};
			if (hit_fm)
				fmt_q <= wd;
			if (hit_bl)
				baudl_q <= wd;
			if (hit_bh)
				baudh_q <= wd[3:0];
			if (hit_st)
				u2x_q <= wd[SERIAL_PORT_SPI_MODE_ST_U2X];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt_q <= 12'h000;
			pre_cnt_q <= 4'h0;
		end
		else if (pre_tick)
		begin
			div_cnt_q <= 12'h000;
			pre_cnt_q <= (pre_cnt_q >= fac_last) ? 4'h0 : pre_cnt_q + 4'h1;
		end
		else
			div_cnt_q <= div_cnt_q + 12'h001;
	end

	assign bit_rate_tick = pre_tick && (pre_cnt_q >= fac_last);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txbuf_q  <= SERIAL_PORT_SPI_MODE_RST_DATA;
			txfull_q <= 1'b0;
		end
		else if (wr_data)
		begin
			txbuf_q  <= wd;
			txfull_q <= 1'b1;
		end
		else if (load)
			txfull_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			tx_active_q <= 1'b0;
		else if (transmitter_enable)
			tx_active_q <= 1'b1;
		else if (!busy && !txfull_q)
			tx_active_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			txc_q <= SERIAL_PORT_SPI_MODE_RST_STATUS[SERIAL_PORT_SPI_MODE_ST_TXC];
		else if (frame_end && !txfull_q)
			txc_q <= 1'b1;
		else if (irq_tx_complete_ack || (wr && hit_st && wd[SERIAL_PORT_SPI_MODE_ST_TXC]))
			txc_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= SERIAL_PORT_SPI_MODE_ST_IDLE;
		else
		begin
			case (state_q)
				SERIAL_PORT_SPI_MODE_ST_IDLE:
					if (load)
						state_q <= SERIAL_PORT_SPI_MODE_ST_SHIFT;
				SERIAL_PORT_SPI_MODE_ST_SHIFT:
					if (frame_end)
						state_q <= SERIAL_PORT_SPI_MODE_ST_IDLE;
				default:
					state_q <= SERIAL_PORT_SPI_MODE_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			txd_q   <= 1'b1;
			bcnt_q  <= 3'd0;
			ecnt_q  <= 4'd0;
		end
		else if (load)
		begin
			tx_sh_q <= cpha ? txbuf_q : shift_in(txbuf_q, lsb_first, 1'b1);
			txd_q   <= cpha ? txd_q : out_bit(txbuf_q, lsb_first);
			bcnt_q  <= 3'd0;
			ecnt_q  <= 4'd0;
		end
		else
		begin
			if (setup && !last_samp)
			begin
				txd_q   <= out_bit(tx_sh_q, lsb_first);
				tx_sh_q <= shift_in(tx_sh_q, lsb_first, 1'b1);
			end
			if (sample)
			begin
				rx_sh_q <= shift_in(rx_sh_q, lsb_first, rxd_s2_q);
				bcnt_q  <= bcnt_q + 3'd1;
			end
			if (mst_edge)
				ecnt_q <= ecnt_q + 4'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			clk_q <= 1'b0;
		else if (mst_edge)
			clk_q <= !clk_q;
		else if (!busy)
			clk_q <= cpol;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_wp_q  <= 1'b0;
			rx_rp_q  <= 1'b0;
			rx_cnt_q <= 2'd0;
		end
		else if (rx_flush)
		begin
			rx_wp_q  <= 1'b0;
			rx_rp_q  <= 1'b0;
			rx_cnt_q <= 2'd0;
		end
		else
		begin
			if (rx_push)
				rx_wp_q <= !rx_wp_q;
			if (rd_pop)
				rx_rp_q <= !rx_rp_q;
			rx_cnt_q <= rx_cnt_q + {1'b0, rx_push} - {1'b0, rd_pop};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rx_push)
			rx_mem[rx_wp_q] <= shift_in(rx_sh_q, lsb_first, rxd_s2_q);
	end

	assign xck_o  = clk_q;
	assign xck_oe = is_master;
	assign txd_o     = txd_q;
	assign txd_oe    = tx_active_q;
	assign rxd_claim = rx_on;

	// Interrupt requests stay high while flag and enable are both set.
	// receive-complete request
	assign irq_rx_complete = (rx_cnt_q != 2'd0) && ctrl_q[SERIAL_PORT_SPI_MODE_CT_RX_COMPLETE_IRQ_ENABLE];
	assign irq_tx_complete = txc_q && ctrl_q[SERIAL_PORT_SPI_MODE_CT_TX_COMPLETE_IRQ_ENABLE];
	assign irq_tx_empty    = !txfull_q && ctrl_q[SERIAL_PORT_SPI_MODE_CT_TX_BUFFER_EMPTY_IRQ_ENABLE];

endmodule

// File: src/serial_port_spi_mode_pkg.sv
// Constants, field positions and types of the SPI-mode serial engine.
// Assumes register indices times four give the APB byte address.
package serial_port_spi_mode_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_STATUS = 8'hc0;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_CTRL   = 8'hc1;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_FMT    = 8'hc2;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_BAUDL  = 8'hc4;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_BAUDH  = 8'hc5;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_IDX_DATA   = 8'hc6;

	// Values after reset.
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_RST_STATUS = 8'h20;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_RST_CTRL   = 8'h00;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_RST_FMT    = 8'h06;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_RST_BAUDL  = 8'h00;
	localparam logic [3:0] SERIAL_PORT_SPI_MODE_RST_BAUDH  = 4'h0;
	localparam logic [7:0] SERIAL_PORT_SPI_MODE_RST_DATA   = 8'h00;

	// Status register fields.
	localparam int SERIAL_PORT_SPI_MODE_ST_RXC  = 7;
	localparam int SERIAL_PORT_SPI_MODE_ST_TXC  = 6;
	localparam int SERIAL_PORT_SPI_MODE_ST_TX_BUFFER_EMPTY_FLAG = 5;
	localparam int SERIAL_PORT_SPI_MODE_ST_U2X  = 1;

	// Control register fields.
	localparam int SERIAL_PORT_SPI_MODE_CT_RX_COMPLETE_IRQ_ENABLE = 7;
	localparam int SERIAL_PORT_SPI_MODE_CT_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int SERIAL_PORT_SPI_MODE_CT_TX_BUFFER_EMPTY_IRQ_ENABLE = 5;
	localparam int SERIAL_PORT_SPI_MODE_CT_RECEIVER_ENABLE  = 4;
	localparam int SERIAL_PORT_SPI_MODE_CT_TRANSMITTER_ENABLE  = 3;

	// Format register fields.
	localparam int SERIAL_PORT_SPI_MODE_FM_MODE_HI = 7;
	localparam int SERIAL_PORT_SPI_MODE_FM_MODE_LO = 6;
	localparam int SERIAL_PORT_SPI_MODE_FM_ORDER   = 2;
	localparam int SERIAL_PORT_SPI_MODE_FM_PHASE   = 1;
	localparam int SERIAL_PORT_SPI_MODE_FM_POL     = 0;

	// Clock cycles per bit are (these factors + 1) times (divisor + 1).
	localparam logic [3:0] SERIAL_PORT_SPI_MODE_FAC_ASYNC  = 4'd15;
	localparam logic [3:0] SERIAL_PORT_SPI_MODE_FAC_DOUBLE = 4'd7;
	localparam logic [3:0] SERIAL_PORT_SPI_MODE_FAC_SYNC   = 4'd1;

	localparam logic [2:0] SERIAL_PORT_SPI_MODE_LAST_BIT  = 3'd7;
	localparam logic [3:0] SERIAL_PORT_SPI_MODE_LAST_EDGE = 4'd15;

	typedef enum logic [1:0]
	{
		SERIAL_PORT_SPI_MODE_MODE_ASYNC  = 2'h0,
		SERIAL_PORT_SPI_MODE_MODE_SYNC   = 2'h1,
		SERIAL_PORT_SPI_MODE_MODE_SLAVE  = 2'h2,
		SERIAL_PORT_SPI_MODE_MODE_MASTER = 2'h3
	} serial_port_spi_mode_mode_t;

	typedef enum logic [1:0]
	{
		SERIAL_PORT_SPI_MODE_ST_IDLE  = 2'b01,
		SERIAL_PORT_SPI_MODE_ST_SHIFT = 2'b10
	} serial_port_spi_mode_state_t;

endpackage
